// *** dual_port_semaphore_flags_bench.sv ***
`timescale 1ns/100ps
module dual_port_semaphore_flags_bench;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic [1:0] cmd_op_i = 2'h0;
    logic [2:0] cmd_index_i = 3'h0;
    logic cmd_ready_o, done_o, granted_o, ce_n_o, flag_space_select_n_o;
    logic rw_n_o, oe_n_o, data_oe_o;
    logic [2:0] flag_index_lines_o;
    logic [7:0] flag_o, data_o, data_i;
    int miscompares = 0;
    int tests_run = 0;
    always #5 clk_i = ~clk_i;
    sem_port_host i_dut (.clk_i, .resetn_i, .cmd_valid_i, .cmd_op_i,
        .cmd_index_i, .cmd_ready_o, .done_o, .granted_o, .flag_o, .ce_n_o,
        .flag_space_select_n_o, .rw_n_o, .oe_n_o, .flag_index_lines_o,
        .data_o, .data_oe_o, .data_i);
    sem_flag_device i_dev (.ce_n_i(ce_n_o), .sel_n_i(flag_space_select_n_o),
        .rw_n_i(rw_n_o), .oe_n_i(oe_n_o), .idx_i(flag_index_lines_o),
        .d_i(data_o), .q_o(data_i));
    // ============================================================
    // shared tasks
    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one command, then a bounded wait for its done pulse
    task automatic run(input logic [1:0] op, input logic [2:0] k);
        int n;
        n = 0;
        @(posedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_op_i <= op;
        cmd_index_i <= k;
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (done_o !== 1'b1 && n < 1000);
        if (n >= 1000) begin
            miscompares++;
            $display("BAD done pulse expected 1 seen %b", done_o);
        end
    endtask
    function automatic logic [7:0] owner(input int k);
        return {6'h00, i_dev.own[k]};
    endfunction
    // ============================================================
    // scenarios
    task automatic t_init();
        run(sem_host_pkg::OP_INIT, 3'h0);
        for (int k = 0; k < 8; k++) begin
            chk("owner after host init", 8'h02, owner(k));
            i_dev.b_write(k, 1'b1);
            chk("owner after both init", 8'h00, owner(k));
        end
        $display("test init finished");
    endtask
    task automatic t_claim_release();
        run(sem_host_pkg::OP_CLAIM, 3'h5);
        chk("granted", 8'h01, {7'h00, granted_o});
        chk("claim readback", 8'h00, flag_o);
        i_dev.b_write(5, 1'b0);
        chk("owner while pending", 8'h01, owner(5));
        run(sem_host_pkg::OP_RELEASE, 3'h5);
        chk("owner after release", 8'h02, owner(5));
        run(sem_host_pkg::OP_READ, 3'h5);
        chk("read of taken flag", 8'hff, flag_o);
        i_dev.b_write(5, 1'b1);
        $display("test claim and release finished");
    endtask
    task automatic t_claim_lost();
        i_dev.b_write(3, 1'b0);
        run(sem_host_pkg::OP_CLAIM, 3'h3);
        chk("lost grant", 8'h00, {7'h00, granted_o});
        chk("lost readback", 8'hff, flag_o);
        chk("request withdrawn", 8'h01, {7'h00, i_dev.req_a[3]});
        i_dev.b_write(3, 1'b1);
        $display("test lost claim finished");
    endtask
    task automatic t_claim_wait();
        i_dev.b_write(4, 1'b0);
        fork
            run(sem_host_pkg::OP_CLAIM, 3'h4);
            begin
                repeat (40) @(posedge clk_i);
                i_dev.b_write(4, 1'b1);
            end
        join
        chk("grant after wait", 8'h01, {7'h00, granted_o});
        chk("owner after wait", 8'h01, owner(4));
        run(sem_host_pkg::OP_RELEASE, 3'h4);
        chk("owner freed", 8'h00, owner(4));
        $display("test polled claim finished");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_init();
        t_claim_release();
        t_claim_lost();
        t_claim_wait();
        finish_test();
    end
    // whole run needs a few hundred cycles
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end
endmodule

// *** flag_sync.sv ***
`timescale 1ns/100ps
// two-stage synchroniser for the returned data pins
module flag_sync (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] d_i,
    output logic [7:0] q_o
);

    logic [7:0] meta;
    logic [7:0] next_meta;
    logic [7:0] next_q;

    // first stage feeds only the second stage
    always_comb begin
        next_meta = d_i;
        next_q = meta;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta <= 8'h00;
            q_o <= 8'h00;
        end else begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end

endmodule

// *** sem_flag_device.sv ***
`timescale 1ns/100ps
// ============================================================
// flag space model: port a on pins, port b through b_write
module sem_flag_device (
    input wire logic ce_n_i,
    input wire logic sel_n_i,
    input wire logic rw_n_i,
    input wire logic oe_n_i,
    input wire logic [2:0] idx_i,
    input wire logic [7:0] d_i,
    output logic [7:0] q_o
);
    logic [1:0] own [8]; // 0 free, 1 port a, 2 port b
    logic [7:0] req_a;
    logic [7:0] req_b;
    logic cap;
    logic rd_ok;
    wire rd = !sel_n_i && !oe_n_i && rw_n_i && ce_n_i;
    // power-up content arbitrary: both sides pending, a owning all
    initial begin
        req_a = 8'h00;
        req_b = 8'h00;
        cap = 1'b1;
        rd_ok = 1'b0;
        foreach (own[i]) own[i] = 2'h1;
    end
    // a release hands over to a pending side before freeing
    function automatic void settle(input int k);
        if (own[k] == 2'h1 && req_a[k]) own[k] = 2'h0;
        if (own[k] == 2'h2 && req_b[k]) own[k] = 2'h0;
        if (own[k] == 2'h0 && !req_a[k]) own[k] = 2'h1;
        else if (own[k] == 2'h0 && !req_b[k]) own[k] = 2'h2;
    endfunction
    task automatic b_write(input int k, input logic v);
        req_b[k] = v;
        settle(k);
    endtask
    // only bit 0 is stored, addressed by the three index lines
    always @(negedge rw_n_i) begin
        if (!sel_n_i && ce_n_i) begin
            req_a[idx_i] = d_i[0];
            settle(int'(idx_i));
        end
    end
    // frozen while the read stays selected
    always @(posedge rd) cap = (own[idx_i] != 2'h1);
    always @(rd) rd_ok <= #50 rd;
    // before access time or when idle the pins show the inverse
    assign q_o = (rd && rd_ok) ? {8{cap}} : ~{8{cap}};
endmodule

// *** sem_host_pkg.sv ***
package sem_host_pkg;

    // ============================================================
    // controller states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_WSET = 6'h02,
        ST_WPUL = 6'h04,
        ST_WEND = 6'h08,
        ST_RACC = 6'h10,
        ST_RGAP = 6'h20
    } state_t;

    // ============================================================
    // user commands
    typedef enum logic [1:0] {
        OP_CLAIM = 2'h0,
        OP_RELEASE = 2'h1,
        OP_INIT = 2'h2,
        OP_READ = 2'h3
    } op_t;

endpackage

// *** sem_host_regs.svh ***
// Overview of operation
// - host requests by writing zero, releases by writing one from this port.
// - host raises select and output enable between successive polling reads.
// - claim is always write zero first, then read back; zero means granted.
// - failed claim keeps polling, then withdraws by writing one.
// - init command writes one to all eight flags.
`ifndef SEM_HOST_REGS_SVH
`define SEM_HOST_REGS_SVH

// ============================================================
// timing figures in ns, clock period in ns
`define SEM_CLK_NS 10
`define SEM_T_AS_NS 10
`define SEM_T_WP_NS 45
`define SEM_T_WR_NS 10
`define SEM_T_ACC_NS 55
`define SEM_T_GAP_NS 20

// ============================================================
// counts and field layout
`define SEM_SYNC_CYC 4'h2
`define SEM_POLL_LIMIT 8'h10
`define SEM_LAST_INDEX 3'h7
`define SEM_FIRST_INDEX 3'h0
`define SEM_BIT_RELEASE 1'h1
`define SEM_BIT_REQUEST 1'h0
`define SEM_ALL_ZERO 8'h00
`define SEM_FLAG_RESET 8'hff

`endif

// *** sem_port_host.sv ***
`timescale 1ns/100ps
`include "sem_host_regs.svh"
// drives one port of the flag space of a dual-port memory
module sem_port_host (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic cmd_valid_i,
    input wire logic [1:0] cmd_op_i,
    input wire logic [2:0] cmd_index_i,
    output logic cmd_ready_o,
    output logic done_o,
    output logic granted_o,
    output logic [7:0] flag_o,
    output logic ce_n_o,
    output logic flag_space_select_n_o,
    output logic rw_n_o,
    output logic oe_n_o,
    output logic [2:0] flag_index_lines_o,
    output logic [7:0] data_o,
    output logic data_oe_o,
    input wire logic [7:0] data_i
);

    // ============================================================
    // helpers
    // least time rounded up to whole cycles, never below one
    function automatic logic [3:0] ns_to_cyc(input int ns);
        int c;
        c = (ns + `SEM_CLK_NS - 1) / `SEM_CLK_NS;
        if (c < 1) c = 1;
        return c[3:0];
    endfunction

    // ============================================================
    // state
    sem_host_pkg::state_t state, next_state;
    sem_host_pkg::op_t op, next_op;
    logic [3:0] cnt, next_cnt;
    logic [2:0] idx, next_idx;
    logic [7:0] polls, next_polls;
    logic wr_bit, next_wr_bit;
    logic sel_n, next_sel_n;
    logic rw_n, next_rw_n;
    logic oe_n, next_oe_n;
    logic doe, next_doe;
    logic done, next_done;
    logic granted, next_granted;
    logic [7:0] flag, next_flag;
    logic [7:0] din_sync;

    flag_sync u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .d_i(data_i),
        .q_o(din_sync)
    );

    // ============================================================
    // sequencer
    always_comb begin
        next_state = state;
        next_op = op;
        next_cnt = cnt;
        next_idx = idx;
        next_polls = polls;
        next_wr_bit = wr_bit;
        next_sel_n = sel_n;
        next_rw_n = rw_n;
        next_oe_n = oe_n;
        next_doe = doe;
        next_done = 1'b0;
        next_granted = granted;
        next_flag = flag;
        case (state)
            sem_host_pkg::ST_IDLE: begin
                // chip enable and select high: port rests in standby
                next_sel_n = 1'b1;
                next_rw_n = 1'b1;
                next_oe_n = 1'b1;
                next_doe = 1'b0;
                if (cmd_valid_i) begin
                    next_op = sem_host_pkg::op_t'(cmd_op_i);
                    next_idx = cmd_index_i;
                    next_polls = 8'h00;
                    next_granted = 1'b0;
                    case (sem_host_pkg::op_t'(cmd_op_i))
                        sem_host_pkg::OP_CLAIM: begin
                            // write comes before any read
                            next_wr_bit = `SEM_BIT_REQUEST;
                            next_state = sem_host_pkg::ST_WSET;
                        end
                        sem_host_pkg::OP_RELEASE: begin
                            next_wr_bit = `SEM_BIT_RELEASE;
                            next_state = sem_host_pkg::ST_WSET;
                        end
                        sem_host_pkg::OP_INIT: begin
                            // sweep every flag from index zero
                            next_idx = `SEM_FIRST_INDEX;
                            next_wr_bit = `SEM_BIT_RELEASE;
                            next_state = sem_host_pkg::ST_WSET;
                        end
                        default: begin
                            next_state = sem_host_pkg::ST_RACC;
                        end
                    endcase
                    next_cnt = (sem_host_pkg::op_t'(cmd_op_i) ==
                                sem_host_pkg::OP_READ) ?
                        ns_to_cyc(`SEM_T_ACC_NS) + `SEM_SYNC_CYC - 4'h1 :
                        ns_to_cyc(`SEM_T_AS_NS) - 4'h1;
                    next_sel_n = 1'b0;
                    next_oe_n = (sem_host_pkg::op_t'(cmd_op_i) !=
                                 sem_host_pkg::OP_READ);
                    next_doe = (sem_host_pkg::op_t'(cmd_op_i) !=
                                sem_host_pkg::OP_READ);
                end
            end
            sem_host_pkg::ST_WSET: begin
                // address and data settle before the strobe falls
                if (cnt == 4'h0) begin
                    next_rw_n = 1'b0;
                    next_cnt = ns_to_cyc(`SEM_T_WP_NS) - 4'h1;
                    next_state = sem_host_pkg::ST_WPUL;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            sem_host_pkg::ST_WPUL: begin
                if (cnt == 4'h0) begin
                    next_rw_n = 1'b1;
                    next_sel_n = 1'b1;
                    next_cnt = ns_to_cyc(`SEM_T_WR_NS) - 4'h1;
                    next_state = sem_host_pkg::ST_WEND;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            sem_host_pkg::ST_WEND: begin
                // data held past the strobe, then released except between init writes
                if (cnt == 4'h0) begin
                    next_doe = 1'b0;
                    if (op == sem_host_pkg::OP_CLAIM &&
                        wr_bit == `SEM_BIT_REQUEST) begin
                        next_sel_n = 1'b0;
                        next_oe_n = 1'b0;
                        next_cnt = ns_to_cyc(`SEM_T_ACC_NS) +
                                   `SEM_SYNC_CYC - 4'h1;
                        next_state = sem_host_pkg::ST_RACC;
                    end else if (op == sem_host_pkg::OP_INIT &&
                                 idx != `SEM_LAST_INDEX) begin
                        next_idx = idx + 3'h1;
                        next_sel_n = 1'b0;
                        next_doe = 1'b1;
                        next_cnt = ns_to_cyc(`SEM_T_AS_NS) - 4'h1;
                        next_state = sem_host_pkg::ST_WSET;
                    end else begin
                        next_done = 1'b1;
                        next_state = sem_host_pkg::ST_IDLE;
                    end
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            sem_host_pkg::ST_RACC: begin
                // device holds its value while both strobes stay low
                if (cnt == 4'h0) begin
                    next_flag = din_sync;
                    next_sel_n = 1'b1;
                    next_oe_n = 1'b1;
                    next_cnt = ns_to_cyc(`SEM_T_GAP_NS) - 4'h1;
                    next_state = sem_host_pkg::ST_RGAP;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            sem_host_pkg::ST_RGAP: begin
                // all bits zero means this port holds the token
                if (cnt != 4'h0) begin
                    next_cnt = cnt - 4'h1;
                end else if (op != sem_host_pkg::OP_CLAIM) begin
                    next_done = 1'b1;
                    next_state = sem_host_pkg::ST_IDLE;
                end else if (flag == `SEM_ALL_ZERO) begin
                    next_granted = 1'b1;
                    next_done = 1'b1;
                    next_state = sem_host_pkg::ST_IDLE;
                end else if (polls == `SEM_POLL_LIMIT) begin
                    // never leave a pending zero behind
                    next_wr_bit = `SEM_BIT_RELEASE;
                    next_sel_n = 1'b0;
                    next_doe = 1'b1;
                    next_cnt = ns_to_cyc(`SEM_T_AS_NS) - 4'h1;
                    next_state = sem_host_pkg::ST_WSET;
                end else begin
                    next_polls = polls + 8'h01;
                    next_sel_n = 1'b0;
                    next_oe_n = 1'b0;
                    next_cnt = ns_to_cyc(`SEM_T_ACC_NS) +
                               `SEM_SYNC_CYC - 4'h1;
                    next_state = sem_host_pkg::ST_RACC;
                end
            end
            default: begin
                next_state = sem_host_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= sem_host_pkg::ST_IDLE;
            op <= sem_host_pkg::OP_CLAIM;
            cnt <= 4'h0;
            idx <= 3'h0;
            polls <= 8'h00;
            wr_bit <= `SEM_BIT_RELEASE;
            sel_n <= 1'b1;
            rw_n <= 1'b1;
            oe_n <= 1'b1;
            doe <= 1'b0;
            done <= 1'b0;
            granted <= 1'b0;
            flag <= `SEM_FLAG_RESET;
        end else begin
            state <= next_state;
            op <= next_op;
            cnt <= next_cnt;
            idx <= next_idx;
            polls <= next_polls;
            wr_bit <= next_wr_bit;
            sel_n <= next_sel_n;
            rw_n <= next_rw_n;
            oe_n <= next_oe_n;
            doe <= next_doe;
            done <= next_done;
            granted <= next_granted;
            flag <= next_flag;
        end
    end

    // ============================================================
    // pins and results
    // memory array stays deselected for all flag traffic
    assign ce_n_o = 1'b1;
    assign flag_space_select_n_o = sel_n;
    assign rw_n_o = rw_n;
    assign oe_n_o = oe_n;
    assign flag_index_lines_o = idx;
    // only the lowest bit matters; upper bits copy it
    assign data_o = {8{wr_bit}};
    assign data_oe_o = doe;
    assign cmd_ready_o = (state == sem_host_pkg::ST_IDLE);
    assign done_o = done;
    assign granted_o = granted;
    assign flag_o = flag;

endmodule

// *** sem_port_host_checker.sv ***
`timescale 1ns/100ps
// ============================================================
// pin checks on one host port of the flag space
module sem_port_host_checker (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic cmd_valid_i,
    input wire logic [1:0] cmd_op_i,
    input wire logic [2:0] cmd_index_i,
    input wire logic cmd_ready_o,
    input wire logic done_o,
    input wire logic granted_o,
    input wire logic [7:0] flag_o,
    input wire logic ce_n_o,
    input wire logic flag_space_select_n_o,
    input wire logic rw_n_o,
    input wire logic oe_n_o,
    input wire logic [2:0] flag_index_lines_o,
    input wire logic [7:0] data_o,
    input wire logic data_oe_o,
    input wire logic [7:0] data_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // memory array stays deselected, so idle means standby
    a_mem_off: assert property (ce_n_o)
        else $error("memory enable driven active");
    a_write_ctl: assert property (
        !rw_n_o |-> !flag_space_select_n_o && data_oe_o)
        else $error("write strobe without select or data");
    a_read_ctl: assert property (
        !oe_n_o |-> rw_n_o && !data_oe_o && !flag_space_select_n_o)
        else $error("output enable outside a read");
    // setup, pulse length and data hold around each write
    a_pulse_len: assert property (
        $fell(rw_n_o) |-> !$past(flag_space_select_n_o) ##0
        !rw_n_o[*5] ##1 data_oe_o)
        else $error("write pulse timing wrong");
    a_data_rep: assert property (
        data_oe_o |-> data_o == 8'h00 || data_o == 8'hff)
        else $error("write data not a full request or release");
    a_addr_stable: assert property (
        !flag_space_select_n_o && !$past(flag_space_select_n_o) |->
        $stable(flag_index_lines_o))
        else $error("index moved inside a cycle");
    // polling reads need a deselected gap or the latch never refreshes;
    // a write followed by its readback may reselect after one cycle
    a_poll_gap: assert property (
        $rose(oe_n_o) |=> flag_space_select_n_o && oe_n_o)
        else $error("read gap shorter than two cycles");
    a_grant_flag: assert property ($rose(granted_o) |->
        flag_o == 8'h00)
        else $error("grant without a zero readback");
    a_done_ready: assert property (done_o |=> cmd_ready_o && !done_o)
        else $error("done not followed by ready");
    c_grant: cover property ($rose(granted_o));
    c_write: cover property ($fell(rw_n_o));
    c_read: cover property ($fell(oe_n_o));
endmodule
bind sem_port_host sem_port_host_checker i_chk (.clk_i, .resetn_i,
    .cmd_valid_i, .cmd_op_i, .cmd_index_i, .cmd_ready_o, .done_o,
    .granted_o, .flag_o, .ce_n_o, .flag_space_select_n_o, .rw_n_o,
    .oe_n_o, .flag_index_lines_o, .data_o, .data_oe_o, .data_i);
